// *** tcl_consts.vh ***
// Purpose: constants for the temperature compensation table indexer
// Assumes: 50 MHz reference clock
// Notes:   table page of four 64-entry tables
`ifndef TCL_CONSTS_VH
`define TCL_CONSTS_VH
`define TCL_BASE_SETPOINT   8'h00
`define TCL_BASE_MODULATION 8'h40
`define TCL_BASE_FAULT      8'h80
`define TCL_BASE_ALARM      8'hc0
`define TCL_AVG_COUNT       5'h10
`define TCL_AVG_SHIFT       4
`define TCL_INDEX_MAX       9'sh03f
`define TCL_ENTRY_RESET     8'h00
`define TCL_INDEX_RESET     6'h00
`endif

// *** tcl_indexer.v ***
// Purpose: average temperature samples, index four offset tables, apply offsets
// Assumes: samples arrive as one-cycle strobes from same-clock converter logic
// Notes:   host table writes come in over a plain write port
`include "tcl_consts.vh"

module tcl_indexer #(
	parameter DAC_W = 8
) (
	// Clock and reset
	input  wire               REF_CLK,
	input  wire               NRST,
	// Temperature converter
	input  wire               SAMPLE_VALID,
	input  wire signed [7:0]  SAMPLE_TEMP,
	// Host table writes and settings
	input  wire               TABLE_WE,
	input  wire [7:0]         TABLE_ADDR,
	input  wire [7:0]         TABLE_WDATA,
	input  wire [3:0]         RANGE_SHIFT_SETTING,
	// Nominal values
	input  wire [DAC_W-1:0]   NOM_POWER_LOOP_SETPOINT,
	input  wire [DAC_W-1:0]   NOM_MODULATION_CURRENT,
	input  wire [DAC_W-1:0]   NOM_BIAS_FAULT_THRESHOLD,
	input  wire [DAC_W-1:0]   NOM_BIAS_ALARM_THRESHOLD,
	// Compensated outputs, load strobe, table pointer and average
	output reg  [DAC_W-1:0]   POWER_LOOP_SETPOINT,
	output reg  [DAC_W-1:0]   MODULATION_CURRENT,
	output reg  [DAC_W-1:0]   BIAS_FAULT_THRESHOLD,
	output reg  [DAC_W-1:0]   BIAS_ALARM_THRESHOLD,
	output reg                DAC_LOAD,
	output reg  [5:0]         APPLIED_TABLE_POINTER,
	output reg  signed [7:0]  AVERAGED_TEMPERATURE
);

	// ------------------------------------------------------------
	// Table page storage
	// ------------------------------------------------------------
	reg [7:0] table_mem [0:255];
	integer   i;

	always @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			for (i = 0; i < 256; i = i + 1) begin
				table_mem[i] <= `TCL_ENTRY_RESET;
			end
		end else if (TABLE_WE) begin
			table_mem[TABLE_ADDR] <= TABLE_WDATA;
		end
	end

	// ------------------------------------------------------------
	// Sample averaging
	// ------------------------------------------------------------
	reg signed [11:0] acc;
	reg [4:0]         count;
	reg               avg_ready;
	wire signed [11:0] next_acc;

	assign next_acc = acc + {{4{SAMPLE_TEMP[7]}}, SAMPLE_TEMP};

	always @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			acc                  <= 12'h000;
			count                <= 5'h00;
			avg_ready            <= 1'b0;
			AVERAGED_TEMPERATURE <= 8'h00;
		end else begin
			avg_ready <= 1'b0;
			if (SAMPLE_VALID) begin
				if (count == `TCL_AVG_COUNT - 5'h01) begin
					// Arithmetic shift keeps floor division for negatives
					AVERAGED_TEMPERATURE <= next_acc[11:4];
					acc                  <= 12'h000;
					count                <= 5'h00;
					avg_ready            <= 1'b1;
				end else begin
					acc   <= next_acc;
					count <= count + 5'h01;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Index with clamp and hysteresis
	// ------------------------------------------------------------
	// Half-degree-step position: raw index doubled plus remainder bit
	wire signed [9:0] raw_index;
	wire signed [9:0] clamped;
	wire signed [9:0] held;
	reg               move;

	// Floor of average/2 plus range shift
	assign raw_index = {{3{AVERAGED_TEMPERATURE[7]}}, AVERAGED_TEMPERATURE[7:1]}
			+ {6'h00, RANGE_SHIFT_SETTING};
	assign clamped = (raw_index < 10'sh000) ? 10'sh000 :
			(raw_index > 10'sh03f) ? 10'sh03f : raw_index;
	assign held = {4'h0, APPLIED_TABLE_POINTER};

	// Beyond neighbour midpoint means at least two steps away in degrees,
	// i.e. raw index differs by more than one, or by one with far half
	always @* begin
		move = 1'b0;
		if (raw_index > held + 10'sh001)
			move = 1'b1;
		else if (raw_index < held - 10'sh001)
			move = 1'b1;
		else if (raw_index == held + 10'sh001 && AVERAGED_TEMPERATURE[0])
			move = 1'b1;
		else if (raw_index == held - 10'sh001 && !AVERAGED_TEMPERATURE[0])
			move = 1'b1;
	end

	reg update;

	always @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			APPLIED_TABLE_POINTER <= `TCL_INDEX_RESET;
			update                <= 1'b0;
		end else begin
			update <= avg_ready;
			if (avg_ready && move) begin
				APPLIED_TABLE_POINTER <= clamped[5:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Table fetch and additive compensation
	// ------------------------------------------------------------
	function [DAC_W-1:0] sat_add;
		input [DAC_W-1:0] nom;
		input [7:0]       off;
		reg signed [DAC_W+8:0] sum;
		begin
			sum = $signed({9'h000, nom}) + $signed({{(DAC_W+1){off[7]}}, off});
			if (sum < 0)
				sat_add = {DAC_W{1'b0}};
			else if (sum > $signed({9'h000, {DAC_W{1'b1}}}))
				sat_add = {DAC_W{1'b1}};
			else
				sat_add = sum[DAC_W-1:0];
		end
	endfunction

	wire [7:0] idx8 = {2'b00, APPLIED_TABLE_POINTER};

	always @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			POWER_LOOP_SETPOINT  <= {DAC_W{1'b0}};
			MODULATION_CURRENT   <= {DAC_W{1'b0}};
			BIAS_FAULT_THRESHOLD <= {DAC_W{1'b0}};
			BIAS_ALARM_THRESHOLD <= {DAC_W{1'b0}};
			DAC_LOAD             <= 1'b0;
		end else begin
			DAC_LOAD <= update;
			if (update) begin
				POWER_LOOP_SETPOINT  <= sat_add(NOM_POWER_LOOP_SETPOINT,
					table_mem[idx8 + `TCL_BASE_SETPOINT]);
				MODULATION_CURRENT   <= sat_add(NOM_MODULATION_CURRENT,
					table_mem[idx8 + `TCL_BASE_MODULATION]);
				BIAS_FAULT_THRESHOLD <= sat_add(NOM_BIAS_FAULT_THRESHOLD,
					table_mem[idx8 + `TCL_BASE_FAULT]);
				// Nominal alarm input gets the alarm table offset like the others
				BIAS_ALARM_THRESHOLD <= sat_add(NOM_BIAS_ALARM_THRESHOLD,
					table_mem[idx8 + `TCL_BASE_ALARM]);
			end
		end
	end

endmodule // tcl_indexer

// *** tcl_props.sv ***
// Purpose: timing checks on the table indexer
// Assumes: one clock, async low reset
// Notes:   sees top ports only
module tcl_props(
	input wire logic REF_CLK, NRST, SAMPLE_VALID, DAC_LOAD,
	input wire logic [5:0] APPLIED_TABLE_POINTER,
	input wire logic signed [7:0] AVERAGED_TEMPERATURE,
	input wire logic [7:0] POWER_LOOP_SETPOINT, MODULATION_CURRENT,
	input wire logic [7:0] BIAS_FAULT_THRESHOLD, BIAS_ALARM_THRESHOLD
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt;
	wire last = SAMPLE_VALID && cnt == 4'hf;
	always_ff @(posedge REF_CLK or negedge NRST)
		if (!NRST) cnt <= 4'h0;
		else if (SAMPLE_VALID) cnt <= cnt + 4'h1;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!NRST);
	// ----
	// Update sequence
	// ----
	sequence avg_done; last; endsequence
	sequence upd_seq; ##3 DAC_LOAD ##1 !DAC_LOAD; endsequence
	load_after_a: assert property (avg_done |-> upd_seq) else $error("no load");
	load_cause_a: assert property (DAC_LOAD |-> $past(last, 3)) else $error("stray load");
	avg_hold_a: assert property ($changed(AVERAGED_TEMPERATURE) |-> $past(last)) else $error("avg");
	ptr_hold_a: assert property ($changed(APPLIED_TABLE_POINTER) |-> $past(last, 2)) else $error("ptr");
	sp_upd_a: assert property ($changed(POWER_LOOP_SETPOINT) |-> DAC_LOAD) else $error("sp");
	mod_upd_a: assert property ($changed(MODULATION_CURRENT) |-> DAC_LOAD) else $error("mod");
	flt_upd_a: assert property ($changed(BIAS_FAULT_THRESHOLD) |-> DAC_LOAD) else $error("flt");
	alm_upd_a: assert property ($changed(BIAS_ALARM_THRESHOLD) |-> DAC_LOAD) else $error("alm");
endmodule // tcl_props
bind tcl_indexer tcl_props props_u(.*);

// *** tcl_conv_model.sv ***
// Purpose: temperature converter model
// Assumes: bursts of sixteen samples
// Notes:   idle data inverts so stale values never match
module tcl_conv_model(
	input wire logic clk,
	output logic valid = 1'b0,
	output logic signed [7:0] temp = 8'sh00
);
	timeunit 1ns;
	timeprecision 1ps;
	task automatic burst(input logic signed [7:0] t, input int gap);
		for (int i = 0; i < 16; i++) begin
			#1 valid = 1'b1; temp = t + 8'(i % 2);
			@(posedge clk);
			if (gap > 0) begin
				#1 valid = 1'b0; temp = ~temp;
				repeat (gap - 1) @(posedge clk);
			end
		end
		#1 valid = 1'b0; temp = ~temp;
	endtask
endmodule // tcl_conv_model

// *** tb_temp_comp_lut_indexer.sv ***
// Purpose: self-checking bench for the table indexer
// Assumes: samples alternate t and t+1, so average is t
// Notes:   expected values from a mirror of the tables
module tb_temp_comp_lut_indexer;
	timeunit 1ns;
	timeprecision 1ps;
	logic REF_CLK = 0, NRST = 0, TABLE_WE = 0, SAMPLE_VALID, DAC_LOAD;
	logic signed [7:0] SAMPLE_TEMP, avg;
	logic [7:0] TABLE_ADDR = 0, TABLE_WDATA = 0, outv[4], nom[4] = '{8'h80, 8'h80, 8'hf0, 8'h10};
	logic [3:0] RANGE_SHIFT_SETTING = 0;
	logic [5:0] ptr;
	logic [7:0] mir[4][64] = '{default: 8'h00};
	int miscompares = 0, cmp_count = 0;
	always #10 REF_CLK = ~REF_CLK;
	tcl_conv_model conv_u(.clk(REF_CLK), .valid(SAMPLE_VALID), .temp(SAMPLE_TEMP));
	tcl_indexer dut_u(.REF_CLK(REF_CLK), .NRST(NRST), .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_TEMP(SAMPLE_TEMP),
		.TABLE_WE(TABLE_WE), .TABLE_ADDR(TABLE_ADDR), .TABLE_WDATA(TABLE_WDATA),
		.RANGE_SHIFT_SETTING(RANGE_SHIFT_SETTING), .NOM_POWER_LOOP_SETPOINT(nom[0]),
		.NOM_MODULATION_CURRENT(nom[1]), .NOM_BIAS_FAULT_THRESHOLD(nom[2]), .NOM_BIAS_ALARM_THRESHOLD(nom[3]),
		.POWER_LOOP_SETPOINT(outv[0]), .MODULATION_CURRENT(outv[1]), .BIAS_FAULT_THRESHOLD(outv[2]),
		.BIAS_ALARM_THRESHOLD(outv[3]), .DAC_LOAD(DAC_LOAD), .APPLIED_TABLE_POINTER(ptr),
		.AVERAGED_TEMPERATURE(avg));
	// ----
	// Shared tasks
	// ----
	task automatic chk(input logic [7:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	function automatic logic [7:0] sat(input logic [7:0] n, input logic signed [7:0] o);
		int s = int'(n) + o;
		return s > 255 ? 8'hff : s < 0 ? 8'h00 : 8'(s);
	endfunction
	task automatic close_out;
		$display("checks %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(input int t, i, input logic [7:0] d);
		TABLE_ADDR = 8'(t * 64 + i);
		TABLE_WDATA = d;
		TABLE_WE = 1;
		mir[t][i] = d;
		@(posedge REF_CLK);
		#1 TABLE_WE = 0;
		// Idle edge so the next call never re-raises the strobe in this step
		@(posedge REF_CLK);
		#1;
	endtask
	// One average, then judge average, pointer and all four outputs
	task automatic step(input logic signed [7:0] t, input logic [3:0] sh, input int gap, input logic [5:0] ep);
		int k;
		RANGE_SHIFT_SETTING = sh;
		conv_u.burst(t, gap);
		for (k = 0; k < 20 && DAC_LOAD !== 1'b1; k++) @(posedge REF_CLK) #1;
		if (k == 20) begin
			miscompares++;
			$display("BAD %0t no load", $time);
		end else begin
			chk(avg, t);
			chk(ptr, ep);
			for (k = 0; k < 4; k++) chk(outv[k], sat(nom[k], mir[k][ep]));
		end
	endtask
	initial begin
		repeat (16) @(posedge REF_CLK);
		#1 NRST = 1;
		for (int k = 0; k < 4; k++) chk(outv[k], 8'h00);
		wr(0, 10, 8'h05); wr(1, 10, 8'hfd); wr(2, 10, 8'h7f); wr(3, 10, 8'h80);
		wr(0, 63, 8'h81); wr(3, 0, 8'h33);
		step(20, 0, 0, 10);
		step(22, 0, 2, 10);
		step(23, 0, 0, 11);
		step(21, 0, 2, 11);
		nom[0] = 8'h20;
		step(20, 0, 0, 10);
		step(126, 15, 2, 63);
		step(-101, 0, 0, 0);
		step(10, 3, 2, 8);
		close_out();
	end
endmodule // tb_temp_comp_lut_indexer
